/* File: inc/li_ion_charge_pkg.sv */
`default_nettype none
package li_ion_charge_pkg;
    localparam logic [7:0] ADDR_INT1_STATUS = 8'h04, ADDR_INT1_MASK = 8'h05;
    localparam logic [7:0] ADDR_LOCK = 8'h10, ADDR_FAST_CUR = 8'h11, ADDR_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_VREG = 8'h13, ADDR_CTL_FOUR = 8'h14, ADDR_DEAD_CUR = 8'h15;
    localparam logic [7:0] ADDR_PRE_CUR = 8'h16, ADDR_CTL_SEVEN = 8'h17, ADDR_TIMERS = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h19, ADDR_RESET_CAUSE = 8'h71;
    localparam logic [7:0] MASK_RESET = 8'h7F, LOCK_RESET = 8'h00, CONTROL_RESET = 8'h01;
    localparam logic [7:0] CTL_FOUR_RESET = 8'h05, CTL_SEVEN_RESET = 8'h06, TIMERS_RESET = 8'h00;
    localparam logic [5:0] FAST_CUR_RESET = 6'h0A, VREG_RESET = 6'h20;
    localparam logic [5:0] DEAD_CUR_RESET = 6'h02, PRE_CUR_RESET = 6'h05;
    localparam logic [7:0] CONTROL_WMASK = 8'h03;
    localparam logic [4:0] UNLOCK_KEY = 5'h15;
    localparam int DEAD_IRQ_BIT = 6, SW_RESET_BIT = 7, CHG_EN_BIT = 0, RECHG_OFS_BIT = 1;
    localparam logic [7:0] CAUSE_POWER_ON = 8'h01, CAUSE_SW_RESET = 8'h02;
    localparam logic [2:0] THERM_MAX_CODE = 3'h6;
    localparam logic [5:0] CUR_5MA_CODE = 6'h00, CV_DERATE_STEP = 6'h04;
    // comparator index order on the synchroniser vector
    localparam int CMP_ABOVE_DEAD = 0, CMP_BELOW_DET_UP = 1, CMP_ABOVE_LOW = 2;
    localparam int CMP_AT_REG = 3, CMP_BELOW_TAPER = 4, CMP_BELOW_RECHG = 5;
    localparam int CMP_DIE_HOT = 6, CMP_VIN_VALID = 7, CMP_BAT_ATTACHED = 8, CMP_COUNT = 9;
    localparam int CLK_PERIOD_NS = 4, TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int DETECT_SETTLE_MS = 1, RECHARGE_DGL_MS = 50;
    localparam int MS_PER_S = 1000, MS_PER_MIN = 60000, MS_PER_HR = 3600000;
    localparam int DEAD_S [4] = '{5, 10, 20, 40};
    localparam int PREQ_MIN [4] = '{15, 30, 45, 60};
    localparam int FAST_HR [4] = '{3, 5, 7, 9};
    localparam int TAPER_MIN [4] = '{5, 10, 20, 40};
    typedef enum logic [3:0] {
        ST_IDLE, ST_DET_SINK, ST_DET_SOURCE, ST_DEAD, ST_PRE,
        ST_CC, ST_CV, ST_TAPER, ST_DONE, ST_FAULT
    } chg_state_t;
endpackage : li_ion_charge_pkg
`default_nettype wire

/* File: design/li_ion_charge_controller.sv */
`default_nettype none
module li_ion_charge_controller #(
    parameter int TICK_CYCLES_P = li_ion_charge_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register port
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    // analog comparators, asynchronous
    input wire logic cmpVbatAboveDead,
    input wire logic cmpVbatBelowDetUp,
    input wire logic cmpVbatAboveLow,
    input wire logic cmpVbatAtReg,
    input wire logic cmpCurrentBelowTaper,
    input wire logic cmpVbatBelowRecharge,
    input wire logic cmpDieHot,
    input wire logic cmpVinValid,
    input wire logic cmpBatAttached,
    // analog charge path controls
    output logic chargeOn,
    output logic [5:0] currentCode,
    output logic [5:0] voltageCode,
    output logic rechargeOffsetSel,
    output logic detectSink,
    output logic detectSource,
    output logic [2:0] thermalThresholdCode,
    output logic deadTimeoutIrq
);
    import li_ion_charge_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] deadLimitMs(input logic [1:0] sel);
        deadLimitMs = 32'(DEAD_S[sel] * MS_PER_S);
    endfunction : deadLimitMs

    function automatic logic [31:0] preqLimitMs(input logic [1:0] sel);
        preqLimitMs = 32'(PREQ_MIN[sel] * MS_PER_MIN);
    endfunction : preqLimitMs

    function automatic logic [31:0] fastLimitMs(input logic [1:0] sel);
        fastLimitMs = 32'(FAST_HR[sel] * MS_PER_HR);
    endfunction : fastLimitMs

    function automatic logic [31:0] taperLimitMs(input logic [1:0] sel);
        taperLimitMs = 32'(TAPER_MIN[sel] * MS_PER_MIN);
    endfunction : taperLimitMs

    ////////////////////////////////////////////////////////////////////////////
    // three-stage synchronisers; value moves only when stages two and three agree
    logic [CMP_COUNT-1:0] cmpRaw;
    logic [CMP_COUNT-1:0] syncA_reg;
    logic [CMP_COUNT-1:0] syncB_reg;
    logic [CMP_COUNT-1:0] syncC_reg;
    logic [CMP_COUNT-1:0] cmp_reg;

    assign cmpRaw = {cmpBatAttached, cmpVinValid, cmpDieHot, cmpVbatBelowRecharge,
        cmpCurrentBelowTaper, cmpVbatAtReg, cmpVbatAboveLow, cmpVbatBelowDetUp,
        cmpVbatAboveDead};

    for (genvar i = 0; i < CMP_COUNT; i++)
    begin : gSync
        always_ff @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
            begin
                syncA_reg[i] <= 1'b0;
                syncB_reg[i] <= 1'b0;
                syncC_reg[i] <= 1'b0;
                cmp_reg[i] <= 1'b0;
            end
            else
            begin
                syncA_reg[i] <= cmpRaw[i];
                syncB_reg[i] <= syncA_reg[i];
                syncC_reg[i] <= syncB_reg[i];
                if (syncB_reg[i] == syncC_reg[i])
                    cmp_reg[i] <= syncC_reg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick shared by every timer
    logic [17:0] tickCnt_reg;
    logic tick_reg;
    wire tickWrap = tickCnt_reg == 18'(TICK_CYCLES_P - 1);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tickCnt_reg <= 18'h00000;
            tick_reg <= 1'b0;
        end
        else
        begin
            tickCnt_reg <= tickWrap ? 18'h00000 : tickCnt_reg + 18'h00001;
            tick_reg <= tickWrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] intStatus_reg, intMask_reg, lock_reg, control_reg, ctlFour_reg;
    logic [7:0] ctlSeven_reg, timers_reg, resetCause_reg, readData_reg;
    logic [5:0] fastCur_reg, vreg_reg, deadCur_reg, preCur_reg;
    logic thermalFlag_reg;
    chg_state_t stateReg, stateNext;

    wire unlocked = lock_reg[4:0] == UNLOCK_KEY;
    wire lockedAddr = regAddr >= ADDR_FAST_CUR && regAddr <= ADDR_TIMERS;
    wire wrOk = regWrite && (!lockedAddr || unlocked);
    wire wrCtl = wrOk && regAddr == ADDR_CONTROL;
    wire swReset = wrCtl && regWriteData[SW_RESET_BIT];
    wire enWrite = wrCtl && regWriteData[CHG_EN_BIT] && !swReset;
    wire wrStatus = regWrite && regAddr == ADDR_INT1_STATUS;
    wire [7:0] statusClr = wrStatus ? regWriteData : 8'h00;
    wire deadExpire;
    wire [7:0] statusSet = {1'b0, deadExpire, 6'h00};
    wire [2:0] thermWrite = regWriteData[2:0] > THERM_MAX_CODE ? THERM_MAX_CODE
        : regWriteData[2:0];

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            resetCause_reg <= CAUSE_POWER_ON;
        else if (swReset)
            resetCause_reg <= CAUSE_SW_RESET;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            intStatus_reg <= 8'h00;
            intMask_reg <= MASK_RESET;
            lock_reg <= LOCK_RESET;
            control_reg <= CONTROL_RESET;
            ctlFour_reg <= CTL_FOUR_RESET;
            ctlSeven_reg <= CTL_SEVEN_RESET;
            timers_reg <= TIMERS_RESET;
            fastCur_reg <= FAST_CUR_RESET;
            vreg_reg <= VREG_RESET;
            deadCur_reg <= DEAD_CUR_RESET;
            preCur_reg <= PRE_CUR_RESET;
        end
        // software reset kept synchronous so the async reset path stays a pure pin
        else if (swReset)
        begin
            intStatus_reg <= 8'h00;
            intMask_reg <= MASK_RESET;
            lock_reg <= LOCK_RESET;
            control_reg <= CONTROL_RESET;
            ctlFour_reg <= CTL_FOUR_RESET;
            ctlSeven_reg <= CTL_SEVEN_RESET;
            timers_reg <= TIMERS_RESET;
            fastCur_reg <= FAST_CUR_RESET;
            vreg_reg <= VREG_RESET;
            deadCur_reg <= DEAD_CUR_RESET;
            preCur_reg <= PRE_CUR_RESET;
        end
        else
        begin
            // a new event outranks a clear in the same cycle
            intStatus_reg <= (intStatus_reg & ~statusClr) | statusSet;
            if (regWrite && regAddr == ADDR_INT1_MASK)
                intMask_reg <= regWriteData;
            if (regWrite && regAddr == ADDR_LOCK)
                lock_reg <= {3'h0, regWriteData[4:0]};
            if (wrCtl)
                control_reg <= regWriteData & CONTROL_WMASK;
            if (wrOk && regAddr == ADDR_CTL_FOUR)
                ctlFour_reg <= regWriteData;
            if (wrOk && regAddr == ADDR_CTL_SEVEN)
                ctlSeven_reg <= {5'h00, thermWrite};
            if (wrOk && regAddr == ADDR_TIMERS)
                timers_reg <= {2'h0, regWriteData[5:0]};
            if (wrOk && regAddr == ADDR_FAST_CUR)
                fastCur_reg <= regWriteData[5:0];
            if (wrOk && regAddr == ADDR_VREG)
                vreg_reg <= regWriteData[5:0];
            if (wrOk && regAddr == ADDR_DEAD_CUR)
                deadCur_reg <= regWriteData[5:0];
            if (wrOk && regAddr == ADDR_PRE_CUR)
                preCur_reg <= regWriteData[5:0];
        end
    end

    wire [7:0] readMux =
        regAddr == ADDR_INT1_STATUS ? intStatus_reg :
        regAddr == ADDR_INT1_MASK ? intMask_reg :
        regAddr == ADDR_LOCK ? lock_reg :
        regAddr == ADDR_FAST_CUR ? {2'h0, fastCur_reg} :
        regAddr == ADDR_CONTROL ? control_reg :
        regAddr == ADDR_VREG ? {2'h0, vreg_reg} :
        regAddr == ADDR_CTL_FOUR ? ctlFour_reg :
        regAddr == ADDR_DEAD_CUR ? {2'h0, deadCur_reg} :
        regAddr == ADDR_PRE_CUR ? {2'h0, preCur_reg} :
        regAddr == ADDR_CTL_SEVEN ? ctlSeven_reg :
        regAddr == ADDR_TIMERS ? timers_reg :
        regAddr == ADDR_STATUS ? {thermalFlag_reg, 3'h0, 4'(stateReg)} :
        regAddr == ADDR_RESET_CAUSE ? resetCause_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // charge sequencer
    logic [31:0] phaseMs_reg, safetyMs_reg;
    logic vinPrev_reg, attachPrev_reg;
    wire inThermal = cmp_reg[CMP_DIE_HOT];
    wire startCycle = (cmp_reg[CMP_VIN_VALID] && !vinPrev_reg)
        || (cmp_reg[CMP_BAT_ATTACHED] && !attachPrev_reg) || enWrite;
    wire stateChange = stateNext != stateReg;
    wire [31:0] deadLimit = deadLimitMs(ctlFour_reg[7:6]);
    wire [31:0] preqLimit = preqLimitMs(timers_reg[1:0]);
    wire [31:0] fastBase = fastLimitMs(timers_reg[3:2]);
    wire [31:0] fastLimit = (stateReg == ST_CC && inThermal) ? fastBase << 1 : fastBase;
    wire [31:0] taperLimit = taperLimitMs(timers_reg[5:4]);
    wire settled = phaseMs_reg >= 32'(DETECT_SETTLE_MS);
    wire preqOver = safetyMs_reg >= preqLimit;
    wire fastOver = safetyMs_reg >= fastLimit;
    wire deadMasked = intMask_reg[DEAD_IRQ_BIT];
    wire inDone = stateReg == ST_DONE;
    wire rechargeLow = cmp_reg[CMP_BELOW_RECHG];
    wire inFast = stateReg == ST_CC || stateReg == ST_CV || stateReg == ST_TAPER;
    wire safetyRun = stateReg == ST_DEAD || stateReg == ST_PRE || inFast;
    wire safetyClr = stateChange && (stateNext == ST_DEAD || stateNext == ST_CC);

    assign deadExpire = stateReg == ST_DEAD && !cmp_reg[CMP_ABOVE_DEAD]
        && phaseMs_reg >= deadLimit;

    always_comb
    begin
        stateNext = stateReg;
        if (!control_reg[CHG_EN_BIT] || !cmp_reg[CMP_VIN_VALID])
            stateNext = ST_IDLE;
        else if (startCycle)
            stateNext = ST_DET_SINK;
        else
        begin
            unique case (stateReg)
                ST_IDLE: stateNext = ST_IDLE;
                ST_DET_SINK:
                    if (settled)
                        stateNext = cmp_reg[CMP_ABOVE_DEAD] ? ST_DEAD : ST_DET_SOURCE;
                ST_DET_SOURCE:
                    if (settled)
                        stateNext = cmp_reg[CMP_BELOW_DET_UP] ? ST_DEAD : ST_IDLE;
                ST_DEAD:
                    if (cmp_reg[CMP_ABOVE_DEAD])
                        stateNext = ST_PRE;
                    else if (deadExpire)
                        stateNext = deadMasked ? ST_PRE : ST_FAULT;
                    else if (preqOver)
                        stateNext = ST_FAULT;
                ST_PRE:
                    if (cmp_reg[CMP_ABOVE_LOW])
                        stateNext = ST_CC;
                    else if (preqOver)
                        stateNext = ST_FAULT;
                ST_CC:
                    if (fastOver)
                        stateNext = ST_FAULT;
                    else if (cmp_reg[CMP_AT_REG])
                        stateNext = ST_CV;
                ST_CV:
                    if (fastOver)
                        stateNext = ST_FAULT;
                    else if (cmp_reg[CMP_BELOW_TAPER])
                        stateNext = ST_TAPER;
                ST_TAPER:
                    if (fastOver)
                        stateNext = ST_FAULT;
                    else if (phaseMs_reg >= taperLimit)
                        stateNext = ST_DONE;
                ST_DONE:
                    if (rechargeLow && phaseMs_reg >= 32'(RECHARGE_DGL_MS))
                        stateNext = ST_CC;
                ST_FAULT: stateNext = ST_FAULT;
                default: stateNext = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateReg <= ST_IDLE;
            vinPrev_reg <= 1'b0;
            attachPrev_reg <= 1'b0;
            thermalFlag_reg <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
            vinPrev_reg <= cmp_reg[CMP_VIN_VALID];
            attachPrev_reg <= cmp_reg[CMP_BAT_ATTACHED];
            thermalFlag_reg <= inThermal;
        end
    end

    // a high recharge comparator must hold without a break, so a drop restarts the count
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phaseMs_reg <= 32'h0000_0000;
            safetyMs_reg <= 32'h0000_0000;
        end
        else
        begin
            if (stateChange || (inDone && !rechargeLow))
                phaseMs_reg <= 32'h0000_0000;
            else if (tick_reg)
                phaseMs_reg <= phaseMs_reg + 32'h0000_0001;
            if (safetyClr)
                safetyMs_reg <= 32'h0000_0000;
            else if (tick_reg && safetyRun)
                safetyMs_reg <= safetyMs_reg + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog controls, registered
    logic [5:0] currentNext, voltageNext;
    logic chargeOn_reg, offsetSel_reg, sink_reg, source_reg, irq_reg;
    logic [5:0] currentCode_reg, voltageCode_reg;
    logic [2:0] thermCode_reg;
    wire [5:0] ccCurrent = (inThermal && fastCur_reg != CUR_5MA_CODE)
        ? {1'b0, fastCur_reg[5:1]} : fastCur_reg;
    wire [5:0] cvVoltage = !inThermal ? vreg_reg
        : (vreg_reg > CV_DERATE_STEP ? vreg_reg - CV_DERATE_STEP : 6'h00);

    assign currentNext = stateReg == ST_DEAD ? deadCur_reg :
        stateReg == ST_PRE ? preCur_reg :
        stateReg == ST_CC ? ccCurrent :
        inFast ? fastCur_reg : 6'h00;
    assign voltageNext = (stateReg == ST_CV || stateReg == ST_TAPER) ? cvVoltage : vreg_reg;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chargeOn_reg <= 1'b0;
            currentCode_reg <= 6'h00;
            voltageCode_reg <= 6'h00;
            offsetSel_reg <= 1'b0;
            sink_reg <= 1'b0;
            source_reg <= 1'b0;
            thermCode_reg <= 3'h0;
            irq_reg <= 1'b0;
            readData_reg <= 8'h00;
        end
        else
        begin
            chargeOn_reg <= safetyRun;
            currentCode_reg <= currentNext;
            voltageCode_reg <= voltageNext;
            offsetSel_reg <= control_reg[RECHG_OFS_BIT];
            sink_reg <= stateReg == ST_DET_SINK;
            source_reg <= stateReg == ST_DET_SOURCE;
            thermCode_reg <= ctlSeven_reg[2:0];
            irq_reg <= intStatus_reg[DEAD_IRQ_BIT] && !deadMasked;
            readData_reg <= readMux;
        end
    end

    assign chargeOn = chargeOn_reg;
    assign currentCode = currentCode_reg;
    assign voltageCode = voltageCode_reg;
    assign rechargeOffsetSel = offsetSel_reg;
    assign detectSink = sink_reg;
    assign detectSource = source_reg;
    assign thermalThresholdCode = thermCode_reg;
    assign deadTimeoutIrq = irq_reg;
    assign regReadData = readData_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence sDeadTimeout;
        stateReg == ST_DEAD && deadExpire && !startCycle && stateNext != ST_IDLE;
    endsequence

    chk_lock_write: assert property (
        regWrite && regAddr == ADDR_FAST_CUR && !unlocked |=> $stable(fastCur_reg))
        else $error("locked register changed");
    chk_dead_advance: assert property (
        stateReg == ST_DEAD && cmp_reg[CMP_ABOVE_DEAD] && stateNext != ST_IDLE
        && !startCycle |=> stateReg == ST_PRE)
        else $error("dead stage did not advance");
    chk_dead_mask: assert property (
        sDeadTimeout |=> (deadMasked ? stateReg == ST_PRE : stateReg == ST_FAULT)
        ##1 intStatus_reg[DEAD_IRQ_BIT] && (irq_reg == !deadMasked))
        else $error("dead timeout handling wrong");
    chk_detect_sink: assert property (
        stateReg == ST_DET_SINK && settled && cmp_reg[CMP_ABOVE_DEAD] && !startCycle
        && stateNext != ST_IDLE |=> stateReg == ST_DEAD ##1 !sink_reg)
        else $error("detect sink outcome wrong");
    chk_cc_derate: assert property (
        stateReg == ST_CC && inThermal && fastCur_reg != CUR_5MA_CODE
        |=> currentCode_reg == ($past(fastCur_reg) >> 1))
        else $error("thermal current not halved");
    chk_thermal_flag: assert property (
        $rose(cmp_reg[CMP_DIE_HOT]) |=> thermalFlag_reg
        ##1 readData_reg[7] || $past(regAddr) != ADDR_STATUS)
        else $error("thermal flag not raised");
    chk_swreset_defaults: assert property (
        swReset |=> lock_reg == LOCK_RESET && intMask_reg == MASK_RESET
        && control_reg == CONTROL_RESET && resetCause_reg == CAUSE_SW_RESET)
        else $error("software reset left values");
    chk_status_sticky: assert property (
        intStatus_reg[DEAD_IRQ_BIT] && !(wrStatus && regWriteData[DEAD_IRQ_BIT]) && !swReset
        |=> intStatus_reg[DEAD_IRQ_BIT])
        else $error("status bit lost");
    chk_fault_hold: assert property (
        stateReg == ST_FAULT && !startCycle |=> stateReg inside {ST_FAULT, ST_IDLE} && !chargeOn_reg)
        else $error("fault state left without trigger");
    chk_recharge: assert property (
        inDone && rechargeLow && phaseMs_reg >= 32'(RECHARGE_DGL_MS) && !startCycle
        && stateNext != ST_IDLE |=> stateReg == ST_CC ##1 safetyMs_reg == 32'h0000_0000)
        else $error("recharge not taken");
endmodule : li_ion_charge_controller
`default_nettype wire

/* File: testbench/battery_model.sv */
`default_nettype none
module battery_model (
    // detect drive from the charger
    input wire logic detectSink,
    input wire logic detectSource,
    // comparator outputs
    output logic aboveDead,
    output logic belowDetUp,
    output logic aboveLow,
    output logic atReg,
    output logic belowRecharge
);
    timeunit 1ns;
    timeprecision 1ps;
    // 0 means no cell: the open pin follows the detect current
    int vbatMv = 0;
    int pinMv;
    always_comb
    begin
        pinMv = (vbatMv != 0) ? vbatMv : ((detectSource && !detectSink) ? 5000 : 0);
        aboveDead = pinMv > 1900;
        belowDetUp = pinMv < 3400;
        aboveLow = pinMv >= 3000;
        atReg = pinMv >= 4200;
        belowRecharge = pinMv < 4060;
    end
endmodule : battery_model
`default_nettype wire

/* File: testbench/tb_li_ion_charge_controller.sv */
`default_nettype none
module tb_li_ion_charge_controller;
    import li_ion_charge_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, reset_n = 0, regWrite = 0, dieHot = 0, vinValid = 0, batAttached = 0;
    logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, regReadData;
    logic aboveDead, belowDetUp, aboveLow, atReg, belowRecharge, chargeOn, detectSink;
    logic detectSource, deadTimeoutIrq;
    logic belowTaper = 0, offsetSel;
    logic [5:0] currentCode, voltageCode;
    logic [2:0] thresholdCode;
    int bad_count = 0, check_count = 0;
    always #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    // short tick keeps the 5 s dead timer near 10000 cycles
    li_ion_charge_controller #(.TICK_CYCLES_P(2)) u_li_ion_charge_controller (
        .clk_sys(clk_sys), .reset_n(reset_n), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .cmpVbatAboveDead(aboveDead), .cmpVbatBelowDetUp(belowDetUp),
        .cmpVbatAboveLow(aboveLow), .cmpVbatAtReg(atReg), .cmpCurrentBelowTaper(belowTaper),
        .cmpVbatBelowRecharge(belowRecharge), .cmpDieHot(dieHot), .cmpVinValid(vinValid),
        .cmpBatAttached(batAttached), .chargeOn(chargeOn), .currentCode(currentCode),
        .voltageCode(voltageCode), .rechargeOffsetSel(offsetSel), .detectSink(detectSink),
        .detectSource(detectSource), .thermalThresholdCode(thresholdCode),
        .deadTimeoutIrq(deadTimeoutIrq)
    );
    battery_model u_battery_model (
        .detectSink(detectSink), .detectSource(detectSource), .aboveDead(aboveDead),
        .belowDetUp(belowDetUp), .aboveLow(aboveLow), .atReg(atReg),
        .belowRecharge(belowRecharge)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        regWrite = 1;
        regAddr = a;
        regWriteData = d;
        @(posedge clk_sys) #1;
        regWrite = 0;
    endtask : wr
    // read data lags the address by one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1;
        regAddr = a;
        @(posedge clk_sys) #1;
        d = regReadData;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("register %h", a), d, exp);
    endtask : rc
    task automatic waitState(input chg_state_t st, input int limit);
        logic [7:0] d;
        for (int i = 0; i < limit; i++)
        begin
            rd(ADDR_STATUS, d);
            if (d[3:0] === st)
                return;
        end
        chk("state", {4'h0, d[3:0]}, {4'h0, st});
        complete_run();
    endtask : waitState
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_sys);
        #1 reset_n = 1;
        rc(ADDR_INT1_MASK, MASK_RESET);
        rc(ADDR_RESET_CAUSE, CAUSE_POWER_ON);
        rc(ADDR_CTL_FOUR, CTL_FOUR_RESET);
        rc(8'h20, 8'h00);
        chk("threshold", {5'h0, thresholdCode}, CTL_SEVEN_RESET);
        wr(ADDR_FAST_CUR, 8'h08);
        rc(ADDR_FAST_CUR, {2'h0, FAST_CUR_RESET});
        wr(ADDR_LOCK, 8'h15);
        wr(ADDR_FAST_CUR, 8'h08);
        rc(ADDR_FAST_CUR, 8'h08);
        // cell at 1.5 V: sink finds it below 1.9 V, source finds it, dead stage times out
        u_battery_model.vbatMv = 1500;
        vinValid = 1;
        batAttached = 1;
        waitState(ST_DEAD, 200);
        chk("chargeOn", {7'h0, chargeOn}, 8'h01);
        chk("dead current", {2'h0, currentCode}, {2'h0, DEAD_CUR_RESET});
        waitState(ST_PRE, 8000);
        rc(ADDR_INT1_STATUS, 8'h40);
        chk("irq", {7'h0, deadTimeoutIrq}, 8'h00);
        chk("pre current", {2'h0, currentCode}, {2'h0, PRE_CUR_RESET});
        wr(ADDR_INT1_STATUS, 8'h00);
        rc(ADDR_INT1_STATUS, 8'h40);
        wr(ADDR_INT1_STATUS, 8'h40);
        rc(ADDR_INT1_STATUS, 8'h00);
        u_battery_model.vbatMv = 3500;
        waitState(ST_CC, 20);
        chk("fast current", {2'h0, currentCode}, 8'h08);
        dieHot = 1;
        repeat (8) @(posedge clk_sys);
        rc(ADDR_STATUS, {4'h8, ST_CC});
        chk("halved current", {2'h0, currentCode}, 8'h04);
        u_battery_model.vbatMv = 4200;
        waitState(ST_CV, 20);
        chk("derated voltage", {2'h0, voltageCode}, {2'h0, VREG_RESET - CV_DERATE_STEP});
        dieHot = 0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("voltage", {2'h0, voltageCode}, {2'h0, VREG_RESET});
        belowTaper = 1;
        waitState(ST_TAPER, 20);
        wr(ADDR_CONTROL, 8'h81);
        rc(ADDR_RESET_CAUSE, CAUSE_SW_RESET);
        rc(ADDR_FAST_CUR, {2'h0, FAST_CUR_RESET});
        rc(ADDR_LOCK, LOCK_RESET);
        rc(ADDR_CONTROL, CONTROL_RESET);
        // unmasked dead timeout on a fresh cycle must stop the charger
        u_battery_model.vbatMv = 1500;
        wr(ADDR_INT1_MASK, 8'h3F);
        wr(ADDR_LOCK, 8'h15);
        wr(ADDR_CONTROL, 8'h03);
        waitState(ST_FAULT, 8000);
        chk("irq", {7'h0, deadTimeoutIrq}, 8'h01);
        chk("chargeOn", {7'h0, chargeOn}, 8'h00);
        chk("offset select", {7'h0, offsetSel}, 8'h01);
        rc(ADDR_INT1_STATUS, 8'h40);
        rc(ADDR_STATUS, {4'h0, ST_FAULT});
        complete_run();
    end
endmodule : tb_li_ion_charge_controller
`default_nettype wire
